// *** core/occ_pkg.sv ***
package occ_pkg;
   localparam logic [15:0] PD_OFS = 16'h0a00;
   localparam logic [15:0] LOOP_OFS = 16'h0a01;
   localparam logic [15:0] SYNC_OFS = 16'h0a02;
   localparam logic [15:0] PROF_C_OFS = 16'h0780;
   localparam logic [15:0] PROF_D_OFS = 16'h07c0;
   localparam logic [5:0] PROF_LAST = 6'h26;
   localparam int unsigned PROF_N = 39;
   localparam logic [5:0] RDIV_B0 = 6'h12;
   localparam logic [5:0] RDIV_B1 = 6'h13;
   localparam logic [5:0] RDIV_B2 = 6'h14;
   localparam int unsigned PD_SRST_BIT = 7;
   localparam int unsigned PD_OSC_BIT = 6;
   localparam int unsigned PD_SYS_BIT = 5;
   localparam int unsigned PD_REF_BIT = 4;
   localparam int unsigned PD_TDC_BIT = 3;
   localparam int unsigned PD_ALOOP_BIT = 2;
   localparam int unsigned PD_DIST_BIT = 1;
   localparam int unsigned PD_FULL_BIT = 0;
   localparam int unsigned LM_HOLD_BIT = 6;
   localparam int unsigned LM_FREE_BIT = 5;
   localparam int unsigned SY_SYNC_BIT = 1;
   localparam logic [7:0] PD_RST = 8'h00;
   localparam logic [7:0] LOOP_RST = 8'h00;
   localparam logic [7:0] SYNC_RST = 8'h00;
   localparam logic [7:0] PD_MASK = 8'hff;
   localparam logic [7:0] LOOP_MASK = 8'h7f;
   localparam logic [7:0] SYNC_MASK = 8'h02;
   typedef enum logic [2:0] {
      SW_AUTO_REV = 3'h0, SW_AUTO_NREV = 3'h1, SW_MAN_FALL = 3'h2,
      SW_MAN_HOLD = 3'h3, SW_MAN_FULL = 3'h4
   } occ_sw_mode_type;
   typedef enum logic [2:0] {TW_LOOP = 3'h1, TW_HIST = 3'h2, TW_FREE = 3'h4} occ_tw_src_type;
   typedef enum logic [2:0] {SY_IDLE = 3'h1, SY_STALL = 3'h2, SY_GO = 3'h4} occ_sync_st_type;
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } occ_req_type;
   // Value a profile byte takes after reset.
   function automatic logic [7:0] prof_rst(input logic [5:0] i);
      case (i)
         6'h0f: prof_rst = 8'hf4;
         6'h10: prof_rst = 8'h01;
         6'h12: prof_rst = 8'hc5;
         6'h15: prof_rst = 8'h6b;
         6'h16: prof_rst = 8'h07;
         6'h18: prof_rst = 8'h04;
         6'h1b: prof_rst = 8'h05;
         6'h1e, 6'h22: prof_rst = 8'hbc;
         6'h1f, 6'h23: prof_rst = 8'h02;
         6'h20, 6'h21, 6'h25, 6'h26: prof_rst = 8'h0a;
         default: prof_rst = 8'h00;
      endcase
   endfunction
   // Writable bits of a profile byte; the rest are reserved.
   function automatic logic [7:0] prof_mask(input logic [5:0] i);
      case (i)
         6'h11, 6'h17: prof_mask = 8'h01;
         6'h14: prof_mask = 8'h1f;
         6'h1a, 6'h1d: prof_mask = 8'h7f;
         default: prof_mask = 8'hff;
      endcase
   endfunction
   // True when an address falls inside the profile block at base.
   function automatic logic prof_hit(input logic [15:0] a, input logic [15:0] base);
      prof_hit = (a[15:6] == base[15:6]) && (a[5:0] <= PROF_LAST);
   endfunction
   // Actual reference division ratio from the three stored bytes.
   function automatic logic [20:0] rdiv_ratio(input logic [7:0] b0, input logic [7:0] b1,
                                               input logic [7:0] b2);
      rdiv_ratio = {1'b0, b2[3:0], b1, b0} + 21'h000001;
   endfunction
endpackage

// *** core/occ_ctrl.sv ***
`timescale 1ns/1ps
module occ_ctrl (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire occ_pkg::occ_req_type req_i,
   input wire logic history_avail_i,
   output logic [7:0] rdata_o,
   output logic soft_reset_o,
   output logic pd_osc_o,
   output logic pd_system_clock_input_o,
   output logic pd_ref_o,
   output logic pd_tdc_o,
   output logic pd_aloop_o,
   output logic pd_dist_o,
   output logic pd_full_o,
   output occ_pkg::occ_tw_src_type tw_src_o,
   output occ_pkg::occ_sw_mode_type sw_mode_o,
   output logic manual_valid_o,
   output logic [1:0] manual_ref_o,
   output logic dist_stall_o,
   output logic dist_restart_o,
   output logic [20:0] rdiv_c_o,
   output logic [20:0] rdiv_d_o
);
   // ==================================================================
   // Address decode
   // ==================================================================
   logic hit_pd;
   logic hit_loop;
   logic hit_sync;
   logic hit_c;
   logic hit_d;
   logic [5:0] ofs;
   logic [7:0] wmask_prof;

   // Decode of the plain register port.
   assign hit_pd = req_i.addr == occ_pkg::PD_OFS;
   assign hit_loop = req_i.addr == occ_pkg::LOOP_OFS;
   assign hit_sync = req_i.addr == occ_pkg::SYNC_OFS;
   assign hit_c = occ_pkg::prof_hit(req_i.addr, occ_pkg::PROF_C_OFS);
   assign hit_d = occ_pkg::prof_hit(req_i.addr, occ_pkg::PROF_D_OFS);
   assign ofs = req_i.addr[5:0];
   assign wmask_prof = occ_pkg::prof_mask(ofs);

   // ==================================================================
   // Control registers
   // ==================================================================
   logic [7:0] pd_ff;
   logic [7:0] loop_ff;
   logic [7:0] sync_ff;

   // Control registers; only the defined bits are stored.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pd_ff <= occ_pkg::PD_RST;
         loop_ff <= occ_pkg::LOOP_RST;
         sync_ff <= occ_pkg::SYNC_RST;
      end else if (req_i.wr) begin
         if (hit_pd) begin
            pd_ff <= req_i.wdata & occ_pkg::PD_MASK;
         end
         if (hit_loop) begin
            loop_ff <= req_i.wdata & occ_pkg::LOOP_MASK;
         end
         if (hit_sync) begin
            sync_ff <= req_i.wdata & occ_pkg::SYNC_MASK;
         end
      end
   end

   // ==================================================================
   // Reference profiles C and D
   // ==================================================================
   logic [7:0] prof_ff [2][occ_pkg::PROF_N];

   // Profile storage; soft reset leaves it untouched.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < occ_pkg::PROF_N; i++) begin
               prof_ff[k][i] <= occ_pkg::prof_rst(6'(i));
            end
         end
      end else if (req_i.wr) begin
         if (hit_c) begin
            prof_ff[0][ofs] <= req_i.wdata & wmask_prof;
         end
         if (hit_d) begin
            prof_ff[1][ofs] <= req_i.wdata & wmask_prof;
         end
      end
   end

   // ==================================================================
   // Read port
   // ==================================================================
   logic [7:0] rd_mux;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;

   // Read selection; unmapped addresses answer zero.
   assign rd_mux = hit_pd ? pd_ff :
                   hit_loop ? loop_ff :
                   hit_sync ? sync_ff :
                   hit_c ? prof_ff[0][ofs] :
                   hit_d ? prof_ff[1][ofs] : 8'h00;
   // Data stands only in the cycle after the read strobe.
   assign nxt_rdata = req_i.rd ? rd_mux : 8'h00;

   // Read data register.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata_o = rdata_ff;

   // ==================================================================
   // Power-down and soft reset outputs
   // ==================================================================
   logic srst;
   logic full;
   logic [7:0] pd_out_ff;
   logic [7:0] nxt_pd_out;

   assign srst = pd_ff[occ_pkg::PD_SRST_BIT];
   assign full = pd_ff[occ_pkg::PD_FULL_BIT];
   assign nxt_pd_out[7] = full;
   assign nxt_pd_out[6] = srst;
   assign nxt_pd_out[5] = pd_ff[occ_pkg::PD_OSC_BIT] | full;
   assign nxt_pd_out[4] = pd_ff[occ_pkg::PD_SYS_BIT] | full;
   assign nxt_pd_out[3] = pd_ff[occ_pkg::PD_REF_BIT] | full;
   assign nxt_pd_out[2] = pd_ff[occ_pkg::PD_TDC_BIT] | full;
   assign nxt_pd_out[1] = pd_ff[occ_pkg::PD_ALOOP_BIT] | full;
   assign nxt_pd_out[0] = pd_ff[occ_pkg::PD_DIST_BIT] | full;

   // Power-down output flops.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         pd_out_ff <= 8'h00;
      end else begin
         pd_out_ff <= nxt_pd_out;
      end
   end

   assign soft_reset_o = pd_out_ff[6];
   assign pd_osc_o = pd_out_ff[5];
   assign pd_system_clock_input_o = pd_out_ff[4];
   assign pd_ref_o = pd_out_ff[3];
   assign pd_tdc_o = pd_out_ff[2];
   assign pd_aloop_o = pd_out_ff[1];
   assign pd_dist_o = pd_out_ff[0];
   // The full power-down flag has its own flop, so other sleep bits cannot fake it.
   assign pd_full_o = pd_out_ff[7];

   // ==================================================================
   // Loop mode decode
   // ==================================================================
   logic f_hold;
   logic f_free;
   logic [2:0] mode_code;
   logic is_manual;
   occ_pkg::occ_tw_src_type nxt_tw_src;
   occ_pkg::occ_sw_mode_type nxt_sw_mode;
   occ_pkg::occ_tw_src_type tw_src_ff;
   occ_pkg::occ_sw_mode_type sw_mode_ff;
   logic manual_valid_ff;
   logic [1:0] manual_ref_ff;
   logic [1:0] nxt_manual_ref;

   assign f_hold = loop_ff[occ_pkg::LM_HOLD_BIT];
   assign f_free = loop_ff[occ_pkg::LM_FREE_BIT];
   assign mode_code = loop_ff[4:2];
   assign nxt_tw_src = f_free ? occ_pkg::TW_FREE :
                       !f_hold ? occ_pkg::TW_LOOP :
                       history_avail_i ? occ_pkg::TW_HIST : occ_pkg::TW_FREE;
   assign nxt_sw_mode = (mode_code > 3'h4) ? occ_pkg::SW_AUTO_REV :
                        occ_pkg::occ_sw_mode_type'(mode_code);
   assign is_manual = (mode_code >= 3'h2) && (mode_code <= 3'h4);
   assign nxt_manual_ref = is_manual ? loop_ff[1:0] : 2'h0;

   // Loop mode output flops.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         tw_src_ff <= occ_pkg::TW_LOOP;
         sw_mode_ff <= occ_pkg::SW_AUTO_REV;
         manual_valid_ff <= 1'b0;
         manual_ref_ff <= 2'h0;
      end else begin
         tw_src_ff <= nxt_tw_src;
         sw_mode_ff <= nxt_sw_mode;
         manual_valid_ff <= is_manual;
         manual_ref_ff <= nxt_manual_ref;
      end
   end

   assign tw_src_o = tw_src_ff;
   assign sw_mode_o = sw_mode_ff;
   assign manual_valid_o = manual_valid_ff;
   assign manual_ref_o = manual_ref_ff;

   // ==================================================================
   // Distribution sync sequencer
   // ==================================================================
   logic sync_bit;
   occ_pkg::occ_sync_st_type sync_st_ff;
   occ_pkg::occ_sync_st_type nxt_sync_st;

   assign sync_bit = sync_ff[occ_pkg::SY_SYNC_BIT];

   // Next state; soft reset returns the sequencer to idle.
   always_comb begin
      nxt_sync_st = sync_st_ff;
      case (sync_st_ff)
         occ_pkg::SY_IDLE: begin
            if (sync_bit) begin
               nxt_sync_st = occ_pkg::SY_STALL;
            end
         end
         occ_pkg::SY_STALL: begin
            if (!sync_bit) begin
               nxt_sync_st = occ_pkg::SY_GO;
            end
         end
         occ_pkg::SY_GO: begin
            nxt_sync_st = sync_bit ? occ_pkg::SY_STALL : occ_pkg::SY_IDLE;
         end
         default: begin
            nxt_sync_st = occ_pkg::SY_IDLE;
         end
      endcase
      if (srst) begin
         nxt_sync_st = occ_pkg::SY_IDLE;
      end
   end

   // Sequencer state register.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         sync_st_ff <= occ_pkg::SY_IDLE;
      end else begin
         sync_st_ff <= nxt_sync_st;
      end
   end

   // One-hot state bits drive the outputs directly.
   assign dist_stall_o = sync_st_ff[1];
   assign dist_restart_o = sync_st_ff[2];

   // ==================================================================
   // Reference divider ratios
   // ==================================================================
   logic [20:0] rdiv_c_ff;
   logic [20:0] rdiv_d_ff;
   logic [20:0] nxt_rdiv_c;
   logic [20:0] nxt_rdiv_d;

   assign nxt_rdiv_c = occ_pkg::rdiv_ratio(prof_ff[0][occ_pkg::RDIV_B0],
                                           prof_ff[0][occ_pkg::RDIV_B1],
                                           prof_ff[0][occ_pkg::RDIV_B2]);
   assign nxt_rdiv_d = occ_pkg::rdiv_ratio(prof_ff[1][occ_pkg::RDIV_B0],
                                           prof_ff[1][occ_pkg::RDIV_B1],
                                           prof_ff[1][occ_pkg::RDIV_B2]);

   // Divider ratio flops.
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         rdiv_c_ff <= 21'h000000;
         rdiv_d_ff <= 21'h000000;
      end else begin
         rdiv_c_ff <= nxt_rdiv_c;
         rdiv_d_ff <= nxt_rdiv_d;
      end
   end

   assign rdiv_c_o = rdiv_c_ff;
   assign rdiv_d_o = rdiv_d_ff;

   // ==================================================================
   // Assertions
   // ==================================================================
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   // A write to a profile C byte followed by a read of it.
   sequence s_wr_rd_c;
      (req_i.wr && hit_c) ##1 (req_i.rd && req_i.addr == $past(req_i.addr));
   endsequence
   sequence s_wr_rd_d;
      (req_i.wr && hit_d) ##1 (req_i.rd && req_i.addr == $past(req_i.addr));
   endsequence

   a_prof_c_back: assert property (
      s_wr_rd_c |=> rdata_o == ($past(req_i.wdata, 2) & occ_pkg::prof_mask($past(ofs, 2))))
      else $error("Profile C read back differs from write.");
   a_prof_d_back: assert property (
      s_wr_rd_d |=> rdata_o == ($past(req_i.wdata, 2) & occ_pkg::prof_mask($past(ofs, 2))))
      else $error("Profile D read back differs from write.");
   a_soft_keep_cfg: assert property (
      (srst && !req_i.wr) |=> (loop_ff == $past(loop_ff)) && dist_stall_o == 1'b0)
      else $error("Soft reset disturbed configuration or left sync stalled.");
   a_osc_sleep: assert property (
      pd_ff[occ_pkg::PD_OSC_BIT] |=> pd_osc_o)
      else $error("Oscillator not asleep.");
   a_sys_sleep: assert property (
      pd_ff[occ_pkg::PD_SYS_BIT] |=> pd_system_clock_input_o)
      else $error("System clock not asleep.");
   a_ref_sleep: assert property (
      pd_ff[occ_pkg::PD_REF_BIT] |=> pd_ref_o)
      else $error("Reference inputs not asleep.");
   a_tdc_aloop_sleep: assert property (
      1'b1 |=> pd_tdc_o == $past(pd_ff[3] | full) && pd_aloop_o == $past(pd_ff[2] | full))
      else $error("Converter or analog loop sleep wrong.");
   a_dist_sleep: assert property (
      !pd_ff[occ_pkg::PD_DIST_BIT] && !full |=> !pd_dist_o)
      else $error("Distribution asleep without request.");
   a_full_sleep: assert property (
      full |=> pd_osc_o && pd_system_clock_input_o && pd_ref_o && pd_tdc_o && pd_aloop_o && pd_dist_o && pd_full_o)
      else $error("Full power-down left a block awake.");
   a_full_flag_clear: assert property (
      !full |=> !pd_full_o)
      else $error("Full power-down flag set without request.");
   a_hold_source: assert property (
      (f_hold && !f_free) |=> tw_src_o == ($past(history_avail_i) ? occ_pkg::TW_HIST : occ_pkg::TW_FREE))
      else $error("Holdover tuning source wrong.");
   a_free_wins: assert property (
      f_free |=> tw_src_o == occ_pkg::TW_FREE)
      else $error("Free-run did not win.");
   a_auto_modes: assert property (
      (mode_code == 3'h1) |=> sw_mode_o == occ_pkg::SW_AUTO_NREV && !manual_valid_o)
      else $error("Automatic policy decode wrong.");
   a_manual_modes: assert property (
      (mode_code == 3'h4) |=> sw_mode_o == occ_pkg::SW_MAN_FULL && manual_valid_o)
      else $error("Manual policy decode wrong.");
   a_manual_ref: assert property (
      (mode_code == 3'h3) |=> manual_ref_o == $past(loop_ff[1:0]))
      else $error("Manual input choice not applied.");
   a_manual_gate: assert property (
      (mode_code < 3'h2) |=> !manual_valid_o && manual_ref_o == 2'h0)
      else $error("Manual field applied in automatic policy.");
   a_sync_stall: assert property (
      (sync_bit && !srst) [*2] |-> dist_stall_o)
      else $error("Outputs not stalled while sync bit set.");
   a_sync_restart: assert property (
      (dist_stall_o && !sync_bit && !srst) |=> dist_restart_o ##1 !dist_restart_o)
      else $error("Restart pulse missing after sync fall.");
   a_restart_cause: assert property (
      dist_restart_o |-> $past(dist_stall_o) && !$past(sync_bit))
      else $error("Restart without falling sync bit.");
   a_rdiv_plus_one: assert property (
      $stable(prof_ff[0][occ_pkg::RDIV_B0]) [*2] |-> rdiv_c_o[7:0] == prof_ff[0][occ_pkg::RDIV_B0] + 8'h01)
      else $error("Divider ratio not one above stored value.");
   a_reserved_zero: assert property (
      (req_i.rd && hit_sync) |=> rdata_o[7:2] == 6'h00 && rdata_o[0] == 1'b0)
      else $error("Reserved sync bits read non-zero.");
   a_read_only_once: assert property (
      !req_i.rd |=> rdata_o == 8'h00)
      else $error("Read data present without read strobe.");

endmodule // occ_ctrl

// *** testbench/clock_chip_operational_controls_test.sv ***
`timescale 1ns/1ps
module clock_chip_operational_controls_test;
   // ==========================================================
   // Signals and clock
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   occ_pkg::occ_req_type req_i = '0;
   logic history_avail_i = 1'b0;
   logic [7:0] rdata_o;
   logic soft_reset_o, pd_osc_o, pd_system_clock_input_o, pd_ref_o, pd_tdc_o, pd_aloop_o, pd_dist_o, pd_full_o;
   occ_pkg::occ_tw_src_type tw_src_o;
   occ_pkg::occ_sw_mode_type sw_mode_o;
   logic manual_valid_o, dist_stall_o, dist_restart_o;
   logic [1:0] manual_ref_o;
   logic [20:0] rdiv_c_o, rdiv_d_o;
   integer num_errors = 0;
   integer n_tests = 0;
   integer seed = 32'h5488dc4b;
   integer cycles = 0;
   logic [7:0] v, rv;
   logic [23:0] dv;
   logic [5:0] ofs;
   logic [2:0] m;
   logic [20:0] exp_tw;
   logic [3:0] c_hi = 4'h0;

   // The clock inverts every half period of 12.5 ns.
   initial begin
      forever #12.5 mclk_i = ~mclk_i;
   end

   occ_ctrl dut (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i), .history_avail_i(history_avail_i),
      .rdata_o(rdata_o), .soft_reset_o(soft_reset_o), .pd_osc_o(pd_osc_o), .pd_system_clock_input_o(pd_system_clock_input_o),
      .pd_ref_o(pd_ref_o), .pd_tdc_o(pd_tdc_o), .pd_aloop_o(pd_aloop_o), .pd_dist_o(pd_dist_o),
      .pd_full_o(pd_full_o), .tw_src_o(tw_src_o), .sw_mode_o(sw_mode_o), .manual_valid_o(manual_valid_o),
      .manual_ref_o(manual_ref_o), .dist_stall_o(dist_stall_o), .dist_restart_o(dist_restart_o),
      .rdiv_c_o(rdiv_c_o), .rdiv_d_o(rdiv_d_o));

   // ==========================================================
   // Bus tasks and checks
   task automatic chk(input logic [20:0] seen, input logic [20:0] expv);
      n_tests = n_tests + 1;
      if (seen !== expv) begin
         num_errors = num_errors + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expv);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      req_i <= '0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      req_i <= '0;
      #1 d = rdata_o;
   endtask

   // Writes a byte and reads it back with the read strobe right after the write strobe.
   task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge mclk_i);
      req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk_i);
      req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk_i);
      req_i <= '0;
      #1 q = rdata_o;
   endtask

   // Lets the derived control outputs follow a register written just before.
   task automatic settle();
      @(posedge mclk_i);
      #1;
   endtask

   // Writable bits of a profile byte, worked out independently of the design.
   function automatic logic [7:0] pmask(input logic [5:0] i);
      if (i == 6'h11 || i == 6'h17) return 8'h01;
      if (i == 6'h14) return 8'h1f;
      if (i == 6'h1a || i == 6'h1d) return 8'h7f;
      return 8'hff;
   endfunction

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         end_of_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      settle();
      rd(occ_pkg::PD_OFS, rv); chk(rv, 8'h00);
      rd(occ_pkg::LOOP_OFS, rv); chk(rv, 8'h00);
      rd(occ_pkg::SYNC_OFS, rv); chk(rv, 8'h00);
      chk(rdiv_c_o, 21'h0000c6);
      chk(rdiv_d_o, 21'h0000c6);
      rd(16'h07c0 + 16'h0012, rv); chk(rv, 8'hc5);
      rd(16'h0780 + 16'h0025, rv); chk(rv, 8'h0a);
      rd(16'h0a03, rv); chk(rv, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 14; i++) begin
         v = (i == 0) ? 8'h01 : (i == 1) ? 8'h80 : 8'($random(seed));
         wr(occ_pkg::PD_OFS, v);
         settle();
         chk({soft_reset_o, pd_osc_o, pd_system_clock_input_o, pd_ref_o, pd_tdc_o, pd_aloop_o, pd_dist_o, pd_full_o},
             {v[7], v[6:1] | {6{v[0]}}, v[0]});
         rd(occ_pkg::PD_OFS, rv); chk(rv, v);
      end
      $display("test power-down done");
      // sync refused while soft reset is held
      wr(occ_pkg::PD_OFS, 8'h80);
      wr(occ_pkg::SYNC_OFS, 8'h02);
      settle(); chk(dist_stall_o, 1'b0);
      wr(occ_pkg::SYNC_OFS, 8'h00);
      settle(); chk(dist_restart_o, 1'b0);
      wr(occ_pkg::PD_OFS, 8'h00);
      // stall then restart on falling edge only
      wr(occ_pkg::SYNC_OFS, 8'hff);
      settle(); chk({dist_stall_o, dist_restart_o}, 2'b10);
      rd(occ_pkg::SYNC_OFS, rv); chk(rv, 8'h02);
      chk({dist_stall_o, dist_restart_o}, 2'b10);
      wr(occ_pkg::SYNC_OFS, 8'h00);
      settle(); chk({dist_stall_o, dist_restart_o}, 2'b01);
      settle(); chk({dist_stall_o, dist_restart_o}, 2'b00);
      $display("test sync done");
      for (int i = 0; i < 24; i++) begin
         m = 3'(i);
         v = 8'($random(seed));
         v[4:2] = m;
         @(posedge mclk_i) history_avail_i <= 1'($random(seed));
         wr(occ_pkg::LOOP_OFS, v);
         settle();
         chk(sw_mode_o, (m > 3'h4) ? 3'h0 : m);
         chk(manual_valid_o, (m >= 3'h2 && m <= 3'h4));
         chk(manual_ref_o, (m >= 3'h2 && m <= 3'h4) ? v[1:0] : 2'h0);
         exp_tw = v[5] ? occ_pkg::TW_FREE : !v[6] ? occ_pkg::TW_LOOP :
                  history_avail_i ? occ_pkg::TW_HIST : occ_pkg::TW_FREE;
         chk(tw_src_o, exp_tw);
         rd(occ_pkg::LOOP_OFS, rv); chk(rv, v & 8'h7f);
      end
      $display("test loop mode done");
      for (int i = 0; i < 6; i++) begin
         dv = 24'($random(seed));
         wr(16'h07c0 + 16'h0012, dv[7:0]);
         wr(16'h07c0 + 16'h0013, dv[15:8]);
         wr_rd(16'h07c0 + 16'h0014, dv[23:16], rv); chk(rv, dv[23:16] & 8'h1f);
         settle();
         chk(rdiv_d_o, {1'b0, dv[19:0]} + 21'h000001);
         chk(rdiv_c_o, {1'b0, c_hi, 16'h00c5} + 21'h000001);
         ofs = 6'h14 + 6'(i * 3);
         v = 8'($random(seed));
         wr_rd(16'h0780 + 16'(ofs), v, rv); chk(rv, v & pmask(ofs));
         if (ofs == 6'h14) c_hi = v[3:0];
         v = (ofs == 6'h14) ? dv[23:16] & 8'h1f : (ofs == 6'h20) ? 8'h0a : (ofs == 6'h23) ? 8'h02 : 8'h00;
         rd(16'h07c0 + 16'(ofs), rv); chk(rv, v);
      end
      wr(16'h07a7, 8'h5a);
      rd(16'h07a7, rv); chk(rv, 8'h00);
      $display("test profiles done");
      end_of_test();
   end
endmodule // clock_chip_operational_controls_test
